// [rtl/pidar_pause_resolve.sv]
/*
 Pause resolution from local and partner pause codes.
 Assumes inputs are held stable while negotiation is complete.
*/
module pidar_pause_resolve (
   input wire logic [1:0] localPause,
   input wire logic [1:0] partnerPause,
   input wire logic negDone,
   output pidar_pkg::pidar_pause_e resolved
);
   // ----------------------------------------
   // Resolution, at most one kind chosen
   // ----------------------------------------
   wire logic locSym = localPause[0];
   wire logic locAsym = localPause[1];
   wire logic parSym = partnerPause[0];
   wire logic parAsym = partnerPause[1];
   wire logic pickSym = locSym && parSym;
   wire logic pickAsym = !pickSym && locAsym && parAsym && (locSym != parSym);
   // Sym wins over asym so both can never be set at once
   assign resolved = !negDone ? pidar_pkg::RES_NONE :
                     pickSym ? pidar_pkg::RES_SYM :
                     pickAsym ? pidar_pkg::RES_ASYM : pidar_pkg::RES_NONE;
endmodule

// [rtl/pidar_pkg.sv]
/*
 Package for the identifier, advertisement and partner ability register bank.
 Assumes one 200 MHz clock, synchronous active-high reset and 16-bit registers.
*/
package pidar_pkg;
   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam logic [4:0] ADDR_ID_LOW = 5'h03;
   localparam logic [4:0] ADDR_ADVERT = 5'h04;
   localparam logic [4:0] ADDR_PARTNER = 5'h05;
   // ----------------------------------------
   // Field positions and masks
   // ----------------------------------------
   localparam int OUI_LSB = 10;
   localparam int MODEL_LSB = 4;
   localparam int REMOTE_FAULT_BIT = 13;
   localparam int PAUSE_LSB = 10;
   localparam int ACK_BIT = 14;
   localparam int NEXT_PAGE_BIT = 15;
   localparam int T4_BIT = 9;
   localparam int TXFD_BIT = 8;
   localparam int TX_BIT = 7;
   localparam int TFD10_BIT = 6;
   localparam int T10_BIT = 5;
   localparam logic [15:0] ADVERT_WMASK = 16'h2dff;
   localparam logic [15:0] PARTNER_MASK = 16'h2fe0;
   // ----------------------------------------
   // Reset values and pause codes
   // ----------------------------------------
   localparam logic [4:0] SELECTOR_8023 = 5'h01;
   localparam logic [1:0] PAUSE_NONE = 2'h0;
   localparam logic [1:0] PAUSE_SYM = 2'h1;
   localparam logic [1:0] PAUSE_ASYM = 2'h2;
   localparam logic [1:0] PAUSE_BOTH = 2'h3;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // Pause resolution outcome
   typedef enum logic [2:0] {
      RES_NONE = 3'b001,
      RES_SYM = 3'b010,
      RES_ASYM = 3'b100
   } pidar_pause_e;
endpackage

// [rtl/pidar_regs.sv]
/*
 Identifier low word, local advertisement and partner ability registers.
 Assumes a management front end issuing one-cycle read/write strobes, and a
 negotiation engine that delivers the received base page as a one-cycle pulse.
*/
module pidar_regs #(
   // Arbitrary neutral identity values, not those of any real part
   parameter logic [5:0] OUI_BITS = 6'h15,
   parameter logic [5:0] MODEL = 6'h2a,
   parameter int REG_WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic softReset,
   input wire logic [2:0] modeStraps,
   input wire logic [3:0] siliconRevision,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic pageValid,
   input wire logic [15:0] pageWord,
   input wire logic negDone,
   input wire logic negRestart,
   output logic [15:0] advertWord,
   output logic pauseSymOn,
   output logic pauseAsymOn
);
   // Elaboration check on width
   if (REG_WIDTH != 16) begin : g_bad_width
      $error("pidar_regs supports only 16-bit registers");
   end

   logic [15:0] idLow;
   logic [15:0] advert;
   logic [15:0] partner;
   logic ackSeen;
   pidar_pkg::pidar_pause_e resolved;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic hitId = regAddr == pidar_pkg::ADDR_ID_LOW;
   wire logic hitAdv = regAddr == pidar_pkg::ADDR_ADVERT;
   wire logic hitPar = regAddr == pidar_pkg::ADDR_PARTNER;
   wire logic anyReset = rst || softReset;

   // Advert reset value built from straps; 100BASE-TX always on
   wire logic [15:0] advertDefault = {
      2'b00, 1'b0, 1'b0, pidar_pkg::PAUSE_NONE, 1'b0,
      modeStraps[2], 1'b1, modeStraps[1], modeStraps[0],
      pidar_pkg::SELECTOR_8023};
   wire logic [15:0] idDefault = {OUI_BITS, MODEL, siliconRevision};

   // ----------------------------------------
   // Identifier low word, writable
   // ----------------------------------------
   // Straps and revision are caught synchronously during reset, not async
   always_ff @(posedge core_clk) begin
      if (anyReset) begin
         idLow <= idDefault;
      end else if (regWrite && hitId) begin
         idLow <= regWrData;
      end
   end

   // ----------------------------------------
   // Advertisement, reserved bits masked
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (anyReset) begin
         advert <= advertDefault;
      end else if (regWrite && hitAdv) begin
         advert <= regWrData & pidar_pkg::ADVERT_WMASK;
      end
   end

   // ----------------------------------------
   // Partner ability capture
   // ----------------------------------------
   // Restart clears stale page so old partner data never looks current;
   // a page landing in the same cycle as a restart wins, so no word is lost
   always_ff @(posedge core_clk) begin
      if (anyReset) begin
         partner <= {pidar_pkg::ZERO16[15:5], pidar_pkg::SELECTOR_8023};
         ackSeen <= 1'b0;
      end else if (pageValid) begin
         partner <= {pidar_pkg::ZERO16[15:5] | (pageWord[15:5] & pidar_pkg::PARTNER_MASK[15:5]),
                     pidar_pkg::SELECTOR_8023};
         ackSeen <= 1'b1;
      end else if (negRestart) begin
         partner <= {pidar_pkg::ZERO16[15:5], pidar_pkg::SELECTOR_8023};
         ackSeen <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read view; partner ignores writes
   // ----------------------------------------
   wire logic [15:0] partnerView = {1'b0, ackSeen, partner[13:0]};
   wire logic [15:0] readMux = hitId ? idLow :
                               hitAdv ? advert :
                               hitPar ? partnerView : pidar_pkg::ZERO16;

   // Read data in the cycle after the strobe only, else zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regRdData <= pidar_pkg::ZERO16;
      end else begin
         regRdData <= regRead ? readMux : pidar_pkg::ZERO16;
      end
   end

   // ----------------------------------------
   // Pause resolution after completion
   // ----------------------------------------
   pidar_pause_resolve u_resolve (
      .localPause(advert[pidar_pkg::PAUSE_LSB +: 2]),
      .partnerPause(partner[pidar_pkg::PAUSE_LSB +: 2]),
      .negDone(negDone),
      .resolved(resolved)
   );

   // Registered so outputs are glitch-free; at most one set
   always_ff @(posedge core_clk) begin
      if (anyReset) begin
         pauseSymOn <= 1'b0;
         pauseAsymOn <= 1'b0;
         advertWord <= pidar_pkg::ZERO16;
      end else begin
         pauseSymOn <= resolved == pidar_pkg::RES_SYM;
         pauseAsymOn <= resolved == pidar_pkg::RES_ASYM;
         advertWord <= advert;
      end
   end
endmodule

// [testbench/pidar_neg_model.sv]
/* Negotiation engine stand-in that hands over received pages.
 Assumes one bench process calls its task. */
module pidar_neg_model (
   input wire logic core_clk,
   output logic pageValid,
   output logic [15:0] pageWord,
   output logic negDone,
   output logic negRestart
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pageValid = 1'b0;
      pageWord = 16'h0000;
      negDone = 1'b0;
      negRestart = 1'b0;
   end
   // One-cycle page or restart; word inverted after so stale data never looks fresh
   task automatic page(input logic [15:0] w, input logic rs);
      @(posedge core_clk);
      pageWord <= w;
      pageValid <= !rs;
      negRestart <= rs;
      @(posedge core_clk);
      pageValid <= 1'b0;
      negRestart <= 1'b0;
      pageWord <= ~w;
      negDone <= !rs;
   endtask
endmodule

// [testbench/pidar_regs_asserts.sv]
/* Checker on the register bank ports.
 Assumes it is bound into pidar_regs below. */
module pidar_regs_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic softReset,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   input wire logic negDone,
   input wire logic [15:0] advertWord,
   input wire logic pauseSymOn,
   input wire logic pauseAsymOn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Soft reset clears state too, so both resets mask the checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst || softReset);
   // Read port answers
   AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("read data not idle");
   AST_PART_FIX: assert property (regRead && regAddr == 5'h05 |=> !regRdData[15] && regRdData[4:0] == 5'h01)
      else $error("partner fixed bits wrong");
   AST_ADV_RSV: assert property (regRead && regAddr == 5'h04 |=> (regRdData & 16'hd200) == 16'h0000)
      else $error("advert reserved bit set");
   AST_UNMAP: assert property (regRead && regAddr > 5'h05 |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   // Advertisement copy follows writes two cycles on
   AST_ADV_WR: assert property (regWrite && regAddr == 5'h04 ##1 !regWrite |=>
      advertWord == ($past(regWrData, 2) & 16'h2dff))
      else $error("advert write lost");
   AST_ADV_WORD: assert property ((advertWord & 16'hd200) == 16'h0000)
      else $error("advert copy reserved bit set");
   // Pause outcome
   AST_PAUSE_ONE: assert property (!(pauseSymOn && pauseAsymOn))
      else $error("both pause settings on");
   AST_PAUSE_GATE: assert property (!$past(negDone) |-> !pauseSymOn && !pauseAsymOn)
      else $error("pause on before completion");
   cover property (regWrite && regAddr == 5'h04);
   cover property (regRead && regAddr == 5'h05);
   cover property (pauseSymOn);
   cover property (pauseAsymOn);
endmodule
bind pidar_regs pidar_regs_asserts pidar_regs_asserts_i (.core_clk, .rst, .softReset, .regAddr, .regWrData,
   .regWrite, .regRead, .regRdData, .negDone, .advertWord, .pauseSymOn, .pauseAsymOn);

// [testbench/pidar_regs_bench.sv]
/* Bench for the register bank: access tasks and fixed expected words.
 Assumes straps and revision change only while a reset is applied. */
module pidar_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, softReset, regWrite, regRead, pageValid, negDone, negRestart, pauseSymOn, pauseAsymOn;
   logic [2:0] modeStraps;
   logic [3:0] siliconRevision;
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, pageWord, advertWord;
   int nErrors = 0, nCompared = 0, cycles = 0;
   pidar_regs pidar_regs_i (.core_clk, .rst, .softReset, .modeStraps, .siliconRevision,
      .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pageValid, .pageWord, .negDone, .negRestart,
      .advertWord, .pauseSymOn, .pauseAsymOn);
   pidar_neg_model pidar_neg_model_i (.core_clk, .pageValid, .pageWord, .negDone, .negRestart);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Hang guard, far beyond the 59 cycles used
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         nErrors++;
         finishTest();
      end
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 check(regRdData, e);
   endtask
   task finishTest();
      $display("errors %0d compared %0d", nErrors, nCompared);
      if (nErrors == 0 && nCompared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      softReset = 1'b0;
      modeStraps = 3'h5;
      siliconRevision = 4'h9;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 5'h00;
      regWrData = 16'h0000;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rd(5'h03, {6'h15, 6'h2a, 4'h9});
      rd(5'h04, 16'h01a1);
      rd(5'h05, 16'h0001);
      $display("reset test ended");
      wr(5'h04, 16'hffff);
      rd(5'h04, 16'h2dff);
      check(advertWord, 16'h2dff);
      wr(5'h05, 16'hffff);
      rd(5'h05, 16'h0001);
      wr(5'h03, 16'h1234);
      rd(5'h03, 16'h1234);
      rd(5'h1f, 16'h0000);
      $display("access test ended");
      wr(5'h04, 16'h0c01);
      pidar_neg_model_i.page(16'hf400, 1'b0);
      rd(5'h05, 16'h6401);
      check({14'h0000, pauseAsymOn, pauseSymOn}, 16'h0001);
      pidar_neg_model_i.page(16'h0000, 1'b1);
      rd(5'h05, 16'h0001);
      check({14'h0000, pauseAsymOn, pauseSymOn}, 16'h0000);
      pidar_neg_model_i.page(16'h0be0, 1'b0);
      rd(5'h05, 16'h4be1);
      check({14'h0000, pauseAsymOn, pauseSymOn}, 16'h0002);
      $display("partner test ended");
      // Soft reset mid-run picks up new straps and revision
      @(posedge core_clk);
      modeStraps <= 3'h2;
      siliconRevision <= 4'h3;
      softReset <= 1'b1;
      @(posedge core_clk);
      softReset <= 1'b0;
      rd(5'h04, 16'h00c1);
      rd(5'h03, {6'h15, 6'h2a, 4'h3});
      rd(5'h05, 16'h0001);
      // Read data must drop back to zero once its cycle is over
      @(posedge core_clk);
      #1 check(regRdData, 16'h0000);
      check({14'h0000, pauseAsymOn, pauseSymOn}, 16'h0000);
      $display("soft reset test ended");
      finishTest();
   end
endmodule
